// file: lbh_pkg.sv
// Purpose : shared constants, types and helpers for the long branch when higher unit
// Assumes : one 20 MHz clock, every clock edge is one bus cycle of the core
// Notes   : flags byte is laid out S X H I N Z V C, most significant bit first

package lbh_pkg;

   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   localparam int unsigned LBH_CLK_HZ     = 20_000_000;

   // ----------------------------------------------------------------
   // opcode and address constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  LBH_PREFIX     = 8'h18;   // page prefix byte
   localparam logic [7:0]  LBH_OPCODE     = 8'h22;   // second opcode byte
   localparam logic [15:0] LBH_INSN_LEN   = 16'h0004; // prefix, opcode, two offset bytes
   localparam logic [15:0] LBH_FETCH_STEP = 16'h0002; // one program word per fetch
   localparam logic [15:0] LBH_ADDR_RST   = 16'h0000;

   // ----------------------------------------------------------------
   // flag bit positions in the condition_flags_register
   // ----------------------------------------------------------------
   localparam int unsigned LBH_FLAG_C     = 0;
   localparam int unsigned LBH_FLAG_Z     = 2;
   localparam logic [7:0]  LBH_FLAGS_RST  = 8'h00;

   // ----------------------------------------------------------------
   // execution lengths in bus cycles, index of the last cycle
   // ----------------------------------------------------------------
   localparam logic [2:0]  LBH_LAST_TAKEN = 3'h3;    // four cycles
   localparam logic [2:0]  LBH_LAST_NOT   = 3'h2;    // three cycles
   localparam logic [2:0]  LBH_IDX_RST    = 3'h0;
   localparam logic [2:0]  LBH_IDX_ONE    = 3'h1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      LBH_ST_IDLE = 5'h01,
      LBH_ST_PFX  = 5'h02,
      LBH_ST_OHI  = 5'h04,
      LBH_ST_OLO  = 5'h08,
      LBH_ST_EXEC = 5'h10
   } lbh_state_t;

   typedef enum logic [1:0] {
      LBH_BC_NONE = 2'h0,   // no bus cycle from this unit
      LBH_BC_FREE = 2'h1,   // internal cycle, bus free
      LBH_BC_PROG = 2'h2    // program word fetch into the queue
   } lbh_bc_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
      logic [15:0] addr;    // address of this byte
   } lbh_qbyte_t;

   typedef struct packed {
      lbh_bc_t     kind;
      logic [15:0] addr;
   } lbh_bus_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // target of the branch, wraps modulo 64 KiB like the program counter
   function automatic logic [15:0] lbh_target(input logic [15:0] base,
                                              input logic [15:0] offset);
      lbh_target = base + LBH_INSN_LEN + offset;
   endfunction : lbh_target

   // bus cycle pattern: taken is free,prog,prog,prog; not taken is free,prog,free
   function automatic lbh_bc_t lbh_cycle_kind(input logic       taken,
                                              input logic [2:0] idx);
      if (taken)
         lbh_cycle_kind = (idx == LBH_IDX_RST) ? LBH_BC_FREE : LBH_BC_PROG;
      else
         lbh_cycle_kind = (idx == LBH_IDX_ONE) ? LBH_BC_PROG : LBH_BC_FREE;
   endfunction : lbh_cycle_kind

endpackage : lbh_pkg

// file: lbh_cond.sv
// Purpose : branch condition for long_branch_when_higher
// Assumes : flags come straight from the condition_flags_register, same clock
// Notes   : purely combinational, never writes any flag

`timescale 1ns/1ps
`default_nettype none

module lbh_cond
   import lbh_pkg::*;
(
   input  wire logic [7:0] flags_i,   // condition_flags_register contents
   output logic            taken_o    // high when the branch goes
);

   // ----------------------------------------------------------------
   // higher test
   // ----------------------------------------------------------------
   // after an unsigned compare, carry clear means no borrow and zero clear
   // means not equal, so together they mean register above memory, or b above a
   assign taken_o = ~(flags_i[LBH_FLAG_C] | flags_i[LBH_FLAG_Z]);

endmodule : lbh_cond

`default_nettype wire

// file: lbh_exec.sv
// Purpose : decode and execute long_branch_when_higher with a sixteen_bit_offset
// Assumes : the queue hands bytes in program order with their addresses;
//           the flags are stable while the last offset byte is taken
// Notes   : one clock edge is one bus cycle; the unit owns the bus while busy

`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - branch when carry and zero both clear
// - after unsigned compare: register above memory
// - after compare_b_with_a: b above a
// - taken: four bus cycles, refill from target
// - not taken: three cycles, continue sequentially
module lbh_exec
   import lbh_pkg::*;
(
   input  wire logic       clk,         // 20 MHz core clock
   input  wire logic       rst_b,       // asynchronous reset, active low
   input  wire lbh_qbyte_t q_byte_i,    // next instruction byte from the queue
   output logic            q_ready_o,   // unit can take a byte this cycle
   input  wire logic [7:0] flags_i,     // condition_flags_register
   output lbh_bus_t        bus_o,       // bus cycle issued this cycle
   output logic            busy_o,      // executing, bus owned
   output logic            pc_load_o,   // one-cycle pulse, load pc_value_o
   output logic [15:0]     pc_value_o,  // new program counter
   output logic            done_o,      // one-cycle pulse, instruction complete
   output logic            taken_o,     // outcome of the last instruction
   output logic            other_op_o,  // one-cycle pulse, bytes are not ours
   output logic [7:0]      flags_o      // flags to write back, unchanged
);

   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      lbh_state_t  st;
      logic [15:0] base;      // address of the prefix byte
      logic [7:0]  off_hi;    // high byte of the offset
      logic [15:0] target;    // branch target
      logic [15:0] seq;       // fall-through address
      logic [15:0] fetch;     // next program word to fetch
      logic        taken;
      logic [2:0]  idx;       // bus cycle index during execution
      lbh_bus_t    bus;
      logic        pc_load;
      logic [15:0] pc_value;
      logic        done;
      logic        other;
      logic [7:0]  flags;
   } lbh_core_t;

   localparam lbh_core_t LBH_CORE_RST = '{
      st       : LBH_ST_IDLE,
      base     : LBH_ADDR_RST,
      off_hi   : 8'h00,
      target   : LBH_ADDR_RST,
      seq      : LBH_ADDR_RST,
      fetch    : LBH_ADDR_RST,
      taken    : 1'b0,
      idx      : LBH_IDX_RST,
      bus      : '{kind: LBH_BC_NONE, addr: LBH_ADDR_RST},
      pc_load  : 1'b0,
      pc_value : LBH_ADDR_RST,
      done     : 1'b0,
      other    : 1'b0,
      flags    : LBH_FLAGS_RST
   };

   lbh_core_t   core_ff;
   lbh_core_t   nxt_core;
   logic        cond_taken;
   logic        take_byte;
   logic [15:0] offset;
   logic [2:0]  last_idx;
   logic        last_cycle;
   lbh_bc_t     kind_now;

   // ----------------------------------------------------------------
   // condition evaluation
   // ----------------------------------------------------------------
   lbh_cond u_cond (
      .flags_i (flags_i),
      .taken_o (cond_taken)
   );

   // ----------------------------------------------------------------
   // handshake and derived terms
   // ----------------------------------------------------------------
   // the queue is held off while executing so no byte of the next
   // instruction is consumed before the refill is under way
   assign q_ready_o  = (core_ff.st != LBH_ST_EXEC);
   assign take_byte  = q_byte_i.valid & q_ready_o;
   assign offset     = {core_ff.off_hi, q_byte_i.data};
   assign last_idx   = core_ff.taken ? LBH_LAST_TAKEN : LBH_LAST_NOT;
   assign last_cycle = (core_ff.idx == last_idx);
   assign kind_now   = lbh_cycle_kind(core_ff.taken, core_ff.idx);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_core          = core_ff;
      // pulses and per-cycle bus drive default to idle
      nxt_core.pc_load  = 1'b0;
      nxt_core.done     = 1'b0;
      nxt_core.other    = 1'b0;
      nxt_core.bus.kind = LBH_BC_NONE;

      unique case (core_ff.st)
         LBH_ST_IDLE:
         begin
            // a lone non-prefix byte belongs to some other decoder
            if (take_byte)
            begin
               if (q_byte_i.data == LBH_PREFIX)
               begin
                  nxt_core.base = q_byte_i.addr;
                  nxt_core.st   = LBH_ST_PFX;
               end
               else
               begin
                  nxt_core.other = 1'b1;
               end
            end
         end

         LBH_ST_PFX:
         begin
            if (take_byte)
            begin
               if (q_byte_i.data == LBH_OPCODE)
               begin
                  nxt_core.st = LBH_ST_OHI;
               end
               else
               begin
                  // another page-two opcode: hand it back
                  nxt_core.other = 1'b1;
                  nxt_core.st    = LBH_ST_IDLE;
               end
            end
         end

         LBH_ST_OHI:
         begin
            if (take_byte)
            begin
               nxt_core.off_hi = q_byte_i.data;
               nxt_core.st     = LBH_ST_OLO;
            end
         end

         LBH_ST_OLO:
         begin
            // flags are sampled with the last offset byte, the latest point
            // at which the preceding compare has surely settled them
            if (take_byte)
            begin
               nxt_core.taken  = cond_taken;
               nxt_core.target = lbh_target(core_ff.base, offset);
               nxt_core.seq    = core_ff.base + LBH_INSN_LEN;
               nxt_core.fetch  = cond_taken ? lbh_target(core_ff.base, offset)
                                            : core_ff.base + LBH_INSN_LEN;
               nxt_core.flags  = flags_i;
               nxt_core.idx    = LBH_IDX_RST;
               nxt_core.st     = LBH_ST_EXEC;
            end
         end

         LBH_ST_EXEC:
         begin
            // one bus cycle per clock: free, then program word fetches; not taken ends with a second free cycle
            nxt_core.bus.kind = kind_now;
            nxt_core.bus.addr = core_ff.fetch;
            if (kind_now == LBH_BC_PROG)
            begin
               nxt_core.fetch = core_ff.fetch + LBH_FETCH_STEP;
            end
            if (last_cycle)
            begin
               // the program counter moves only on a taken branch
               nxt_core.pc_load  = core_ff.taken;
               nxt_core.pc_value = core_ff.taken ? core_ff.target : core_ff.seq;
               nxt_core.done     = 1'b1;
               nxt_core.idx      = LBH_IDX_RST;
               nxt_core.st       = LBH_ST_IDLE;
            end
            else
            begin
               nxt_core.idx = core_ff.idx + LBH_IDX_ONE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         core_ff <= LBH_CORE_RST;
      else
         core_ff <= nxt_core;
   end

   // ----------------------------------------------------------------
   // outputs, all from the state register except the ready handshake
   // ----------------------------------------------------------------
   assign bus_o      = core_ff.bus;
   assign busy_o     = (core_ff.st == LBH_ST_EXEC);
   assign pc_load_o  = core_ff.pc_load;
   assign pc_value_o = core_ff.pc_value;
   assign done_o     = core_ff.done;
   assign taken_o    = core_ff.taken;
   assign other_op_o = core_ff.other;
   // flags pass back exactly as sampled; nothing in this unit alters them
   assign flags_o    = core_ff.flags;

endmodule : lbh_exec

`default_nettype wire

// file: lbh_exec_asserts.sv
// Purpose : port properties of the long branch when higher unit
// Assumes : one clock, reset asynchronous and active low
// Notes   : bound into every lbh_exec instance
`timescale 1ns/1ps
`default_nettype none
module lbh_exec_asserts
   import lbh_pkg::*;
(
   input  wire logic        clk,         // core clock
   input  wire logic        rst_b,       // reset, active low
   input  wire logic [7:0]  flags_i,     // flags into the unit
   input  wire lbh_bus_t    bus_o,       // bus cycle issued
   input  wire logic        busy_o,      // executing
   input  wire logic        pc_load_o,   // pc load pulse
   input  wire logic [15:0] pc_value_o,  // new program counter
   input  wire logic        done_o,      // completion pulse
   input  wire logic        taken_o,     // outcome
   input  wire logic [7:0]  flags_o      // flags written back
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // outcome is fixed by the flags seen with the last offset byte
   a_cond_flags: assert property (
      $rose(busy_o) |-> taken_o == !($past(flags_i[LBH_FLAG_C]) | $past(flags_i[LBH_FLAG_Z])))
      else $error("outcome does not follow carry and zero");
   a_load_taken: assert property (pc_load_o |-> taken_o && done_o)
      else $error("pc loaded without a taken branch");
   // the new pc must be the first refill address
   a_pc_refill: assert property (pc_load_o |-> pc_value_o == $past(bus_o.addr, 2))
      else $error("pc value differs from refill address");
   a_taken_len: assert property ($rose(busy_o) && taken_o |-> busy_o[*4] ##1 !busy_o)
      else $error("taken branch not four cycles");
   a_not_len: assert property ($rose(busy_o) && !taken_o |-> busy_o[*3] ##1 !busy_o)
      else $error("untaken branch not three cycles");
   a_refill_order: assert property (
      $rose(busy_o) && taken_o |=> bus_o.kind == LBH_BC_FREE ##1 bus_o.kind == LBH_BC_PROG
      ##1 (bus_o.kind == LBH_BC_PROG && bus_o.addr == $past(bus_o.addr) + LBH_FETCH_STEP)
      ##1 (bus_o.kind == LBH_BC_PROG && bus_o.addr == $past(bus_o.addr) + LBH_FETCH_STEP))
      else $error("refill fetch pattern wrong");
   a_fall_order: assert property (
      $rose(busy_o) && !taken_o |=> bus_o.kind == LBH_BC_FREE
      ##1 bus_o.kind == LBH_BC_PROG ##1 (bus_o.kind == LBH_BC_FREE && done_o))
      else $error("fall through pattern wrong");
   a_flags_kept: assert property ($rose(busy_o) |-> flags_o == $past(flags_i))
      else $error("flags altered");
endmodule : lbh_exec_asserts
bind lbh_exec lbh_exec_asserts u_lbh_exec_asserts (.clk(clk), .rst_b(rst_b),
   .flags_i(flags_i), .bus_o(bus_o), .busy_o(busy_o), .pc_load_o(pc_load_o),
   .pc_value_o(pc_value_o), .done_o(done_o), .taken_o(taken_o), .flags_o(flags_o));
`default_nettype wire

// file: lbh_queue_model.sv
// Purpose : instruction queue model, offers bytes in program order
// Assumes : a byte is taken on an edge with valid and ready high
// Notes   : released data shows the inverse of the last byte, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module lbh_queue_model
   import lbh_pkg::*;
(
   input  wire logic        clk,      // core clock
   input  wire logic        rst_b,    // reset, active low
   input  wire logic        go,       // load four bytes
   input  wire logic [31:0] insn,     // bytes, first one on top
   input  wire logic [15:0] base,     // address of the first byte
   input  wire logic        q_ready,  // unit takes a byte
   output var  lbh_qbyte_t  q_byte,   // byte offered
   output logic             idle      // nothing left to offer
);
   // ---------------------------------------------------------------
   // byte shifter
   // ---------------------------------------------------------------
   logic [2:0]  cnt_ff;
   logic [31:0] sh_ff;
   logic [15:0] adr_ff;
   logic [7:0]  last_ff;
   assign idle = (cnt_ff == 3'h0);
   // the whole record has one driver, so no member is driven on its own
   assign q_byte = '{valid: !idle, data: (idle ? ~last_ff : sh_ff[31:24]), addr: adr_ff};
   // a byte is held until the unit accepts it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         {cnt_ff, sh_ff, adr_ff, last_ff} <= '0;
      else if (go && idle)
      begin
         cnt_ff <= 3'h4;
         sh_ff  <= insn;
         adr_ff <= base;
      end
      else if (!idle && q_ready)
      begin
         cnt_ff  <= cnt_ff - 3'h1;
         sh_ff   <= {sh_ff[23:0], 8'h00};
         adr_ff  <= adr_ff + 16'h0001;
         last_ff <= sh_ff[31:24];
      end
   end
endmodule : lbh_queue_model
`default_nettype wire

// file: lbh_exec_tb.sv
// Purpose : self-checking bench of the long branch when higher unit
// Assumes : 20 MHz clock, inputs change 5 ns after the rising edge
// Notes   : expected pc is worked out here from base, length four and offset
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module lbh_exec_tb
   import lbh_pkg::*;
;
   logic        clk, rst_b, go, q_ready, busy, pc_load, done, taken, other_op, idle;
   logic [31:0] insn;
   logic [15:0] base, pc_value;
   logic [7:0]  flags, flags_out;
   lbh_qbyte_t  q_byte;
   lbh_bus_t    bus;
   int          errors, num_checks;
   always #25 clk = ~clk;
   lbh_queue_model u_lbh_queue_model (.clk(clk), .rst_b(rst_b), .go(go), .insn(insn),
      .base(base), .q_ready(q_ready), .q_byte(q_byte), .idle(idle));
   lbh_exec u_lbh_exec (.clk(clk), .rst_b(rst_b), .q_byte_i(q_byte), .q_ready_o(q_ready),
      .flags_i(flags), .bus_o(bus), .busy_o(busy), .pc_load_o(pc_load),
      .pc_value_o(pc_value), .done_o(done), .taken_o(taken), .other_op_o(other_op),
      .flags_o(flags_out));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task step;
      @(posedge clk);
      #5;
   endtask : step
   // one whole branch, judged at its completion pulse
   task run_insn(input logic [15:0] a, input logic [15:0] off, input logic [7:0] f,
                 input logic exp);
      logic [15:0] pc;
      logic [15:0] fetch0;
      int          n_busy;
      int          n_stall;
      int          n_prog;
      pc = exp ? a + 16'h0004 + off : a + 16'h0004;
      fetch0 = 16'h0000;
      n_busy = 0;
      n_stall = 0;
      n_prog = 0;
      flags = f;
      base = a;
      insn = {LBH_PREFIX, LBH_OPCODE, off};
      go = 1'b1;
      step();
      go = 1'b0;
      // busy, stalled and fetch cycles are counted up to the completion pulse
      for (int i = 0; i < 20 && done !== 1'b1; i++)
      begin
         step();
         n_busy += int'(busy === 1'b1);
         n_stall += int'(q_ready === 1'b0);
         if (bus.kind === LBH_BC_PROG)
         begin
            if (n_prog == 0)
               fetch0 = bus.addr;
            n_prog++;
         end
      end
      `CHK(done, 1'b1)
      `CHK(pc_value, pc)
      `CHK(pc_load, exp)
      `CHK(taken, exp)
      `CHK(flags_out, f)
      `CHK(n_busy, exp ? 4 : 3)
      `CHK(n_stall, exp ? 4 : 3)
      `CHK(n_prog, exp ? 3 : 1)
      `CHK(fetch0, pc)
      step();
   endtask : run_insn
   // every carry and zero combination, with S, X, N and V set to catch a wrong bit
   task t_flags;
      for (int i = 0; i < 4; i++)
         run_insn(16'h1000, 16'h0100, 8'hCA | {5'h00, i[1], 1'b0, i[0]}, i == 0);
   endtask : t_flags
   // flags of an unsigned subtract: wide register cases, then byte b minus a
   task t_compare;
      logic [15:0] r[5];
      logic [15:0] m[5];
      r = '{16'h8001, 16'h1234, 16'h0001, 16'h0090, 16'h0010};
      m = '{16'h7FFF, 16'h1234, 16'hFFFF, 16'h0010, 16'h0090};
      for (int k = 0; k < 5; k++)
         run_insn(16'h2000, 16'hFF00, {5'h00, r[k] == m[k], 1'b0, r[k] < m[k]},
                  r[k] > m[k]);
   endtask : t_compare
   // target wraps both ways, one branch after the other with idle cycles between them
   task t_wrap;
      run_insn(16'hFFFE, 16'h0010, 8'h00, 1'b1);
      run_insn(16'h0000, 16'h8000, 8'h00, 1'b1);
   endtask : t_wrap
   // wrong second byte and two stray bytes are each flagged, nothing runs
   task t_foreign;
      int n_other;
      int n_done;
      n_other = 0;
      n_done = 0;
      insn = {LBH_PREFIX, 8'h23, 8'h00, 8'h01};
      go = 1'b1;
      step();
      go = 1'b0;
      repeat (12)
      begin
         step();
         n_other += int'(other_op === 1'b1);
         n_done += int'(done === 1'b1);
      end
      `CHK(n_other, 3)
      `CHK(n_done, 0)
      `CHK(idle, 1'b1)
   endtask : t_foreign
   task summarize;
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   // ---------------------------------------------------------------
   // sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      {clk, rst_b, go, insn, base, flags} = '0;
      errors = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      #5 rst_b = 1'b1;
      t_flags();
      t_compare();
      t_wrap();
      t_foreign();
      summarize();
   end
   // whole run needs some 130 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule : lbh_exec_tb
`default_nettype wire
